// ---- hw/comms_pin_mode_defs.svh ----
// Constants for the communication pin multiplexer: settle counts,
// pin counts and press channel patterns.
// Assumes inclusion by bare name from the design files only.
//
// Contract
// RQ1: Strap sampled at every reset; low picks slave I2C, high picks slave SPI.
// RQ2: In slave SPI mode the strap pin becomes the driven MISO output.
// RQ3: First host pin is I2C data, or SPI clock input in SPI mode.
// RQ4: Second host pin is I2C clock, or active-low SPI select in SPI mode.
// RQ5: Third host pin picks one of two I2C addresses, or is SPI MOSI.
// RQ6: Renderer runs master port in exactly one of GPIO, I2C or SPI modes.
// RQ7: GPIO mode drives master pins 0..3 as parallel outputs A..D.
// RQ8: Master I2C: pin0 data, pin1 clock, pin2 attention input, pin3 unused.
// RQ9: Drivers sharing the attention line report their assertion over I2C.
// RQ10: Master SPI: pin0 MOSI out, pin1 SCK out, pin2 MISO in, pin3 select out.
// RQ11: Five general pins with weak pull-ups, freely configured by the host.
// RQ12: When enabled, general pin 1 is line sync and pin 2 frame sync.
// RQ13: Hard reset pin is asynchronous active-low master reset.
// RQ14: Press sensing uses channel 0 only, or all four channels.
// RQ15: Host attention pin driven low while reports wait, else released.
// RQ16: Host senses the attention pin by level, not edge.
// RQ17: Slave mode holds until next reset, ignoring later strap changes.
`ifndef COMMS_PIN_MODE_DEFS_SVH
`define COMMS_PIN_MODE_DEFS_SVH

// Clock edges the strap waits after reset release, covering the synchroniser
`define STRAP_SETTLE_CYCLES 2'h2
`define GENERAL_PIN_COUNT 5
`define MASTER_PIN_COUNT 4
`define LINE_SYNC_PIN 1
`define FRAME_SYNC_PIN 2
`define PRESS_SINGLE_CHANNEL 4'h1
`define PRESS_ALL_CHANNELS 4'hF
// Master port enables for GPIO and SPI modes, bit n belongs to master pin n
`define MASTER_OE_GPIO 4'hF
`define MASTER_OE_SPI 4'hB

`endif

// ---- hw/comms_pin_mode_mux.sv ----
// Communication pin multiplexer: slave host pins picked by a reset strap,
// four-pin master port steered by the renderer, general pins with sync roles,
// press channel enables and the host attention pin.
// Assumes open-drain pins are resolved outside from the enables, and that the
// host SPI clock arrives on link_clk only while host_select_n is low.
`timescale 1ns/1ps
`include "comms_pin_mode_defs.svh"
module comms_pin_mode_mux (
    input wire logic clk,
    input wire logic rst,
    input wire logic hard_reset_n,
    input wire logic link_clk,
    // Strap pin, later the SPI MISO line
    input wire logic host_bus_select_strap_in,
    output logic host_bus_select_strap_out,
    output logic host_bus_select_strap_oe,
    // Shared host pins
    input wire logic host_serial_data_in,
    output logic host_serial_data_out,
    output logic host_serial_data_oe,
    input wire logic host_serial_clock_in,
    input wire logic host_address_pick_in,
    output logic host_attention_n_out,
    output logic host_attention_n_oe,
    // Core side of the slave interface
    input wire logic host_i2c_data_drive_low,
    input wire logic reports_pending,
    output logic host_is_spi,
    output logic host_mode_valid,
    output logic host_i2c_data,
    output logic host_i2c_clock,
    output logic host_address_high,
    output logic host_byte_valid,
    output logic [7:0] host_byte,
    // Master port pins
    input wire logic [`MASTER_PIN_COUNT-1:0] master_port_in,
    output logic [`MASTER_PIN_COUNT-1:0] master_port_out,
    output logic [`MASTER_PIN_COUNT-1:0] master_port_oe,
    // Renderer side of the master port
    input wire logic [1:0] master_mode,
    input wire logic [`MASTER_PIN_COUNT-1:0] parallel_out,
    input wire logic master_serial_data_drive_low,
    input wire logic master_serial_clock_drive_low,
    input wire logic master_data_out,
    input wire logic master_shift_clock,
    input wire logic master_target_select_n,
    output logic master_serial_data,
    output logic master_serial_clock,
    output logic driver_attention_n,
    output logic master_data_in,
    // General pins
    input wire logic [`GENERAL_PIN_COUNT-1:0] general_io_in,
    output logic [`GENERAL_PIN_COUNT-1:0] general_io_out,
    output logic [`GENERAL_PIN_COUNT-1:0] general_io_oe,
    input wire logic [`GENERAL_PIN_COUNT-1:0] general_io_drive,
    input wire logic [`GENERAL_PIN_COUNT-1:0] general_io_value,
    input wire logic line_sync_enable,
    input wire logic frame_sync_enable,
    output logic [`GENERAL_PIN_COUNT-1:0] general_io_level,
    output logic line_sync_in,
    output logic frame_sync_in,
    // Press channels
    input wire logic press_multi_channel,
    output logic [3:0] press_channels
);

    // ----------------------------------------------------------------
    // Reset and synchronisers
    // ----------------------------------------------------------------
    logic rst_all;
    logic link_clear;
    logic strap_level;
    logic [1:0] host_levels;
    logic address_level;
    logic [`MASTER_PIN_COUNT-1:0] master_levels;
    logic [`GENERAL_PIN_COUNT-1:0] general_levels;
    logic toggle_seen;
    logic toggle_prev;

    // Either reset source clears everything at once, no clock needed
    assign rst_all = rst | ~hard_reset_n; // RQ13
    logic host_select_n_raw;
    assign host_select_n_raw = host_serial_clock_in; // RQ4
    // A raised select ends the link frame without relying on a link edge
    assign link_clear = rst_all | host_select_n_raw;

    sync_two_flop #(.WIDTH(1)) strap_sync (
        .clk(clk),
        .rst(rst_all),
        .async_in(host_bus_select_strap_in),
        .sync_out(strap_level)
    );

    sync_two_flop #(.WIDTH(2)) host_sync (
        .clk(clk),
        .rst(rst_all),
        .async_in({host_serial_clock_in, host_serial_data_in}),
        .sync_out(host_levels)
    );

    sync_two_flop #(.WIDTH(1)) address_sync (
        .clk(clk),
        .rst(rst_all),
        .async_in(host_address_pick_in),
        .sync_out(address_level)
    );

    sync_two_flop #(.WIDTH(`MASTER_PIN_COUNT)) master_sync (
        .clk(clk),
        .rst(rst_all),
        .async_in(master_port_in),
        .sync_out(master_levels)
    );

    sync_two_flop #(.WIDTH(`GENERAL_PIN_COUNT)) general_sync (
        .clk(clk),
        .rst(rst_all),
        .async_in(general_io_in),
        .sync_out(general_levels)
    );

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    comms_pin_mode_pkg::host_mode_type host_mode;
    logic [1:0] settle_count;

    // Wait until the synchroniser holds the post-reset strap level,
    // then freeze the choice until the next reset
    always_ff @(posedge clk or posedge rst_all)
    begin
        if (rst_all)
        begin
            host_mode <= comms_pin_mode_pkg::HOST_PENDING;
            settle_count <= 2'h0;
        end
        else if (host_mode == comms_pin_mode_pkg::HOST_PENDING)
        begin
            if (settle_count == `STRAP_SETTLE_CYCLES)
            begin
                host_mode <= strap_level ? comms_pin_mode_pkg::HOST_SPI : comms_pin_mode_pkg::HOST_I2C; // RQ1
            end
            settle_count <= settle_count + 2'h1;
        end
    end

    // ----------------------------------------------------------------
    // Slave host pins
    // ----------------------------------------------------------------
    logic link_miso;

    // Strap pin turns to a driven output only after SPI is chosen;
    // later strap changes are never looked at again
    always_ff @(posedge clk or posedge rst_all)
    begin
        if (rst_all)
        begin
            host_bus_select_strap_oe <= 1'b0;
            host_serial_data_oe <= 1'b0;
            host_is_spi <= 1'b0;
            host_mode_valid <= 1'b0;
            host_i2c_data <= 1'b1;
            host_i2c_clock <= 1'b1;
            host_address_high <= 1'b0;
            host_attention_n_oe <= 1'b0;
        end
        else
        begin
            host_bus_select_strap_oe <= (host_mode == comms_pin_mode_pkg::HOST_SPI); // RQ2 RQ17
            host_is_spi <= (host_mode == comms_pin_mode_pkg::HOST_SPI);
            host_mode_valid <= (host_mode != comms_pin_mode_pkg::HOST_PENDING);
            // Open-drain data: pull low only, and only in I2C mode
            host_serial_data_oe <= (host_mode == comms_pin_mode_pkg::HOST_I2C) && host_i2c_data_drive_low; // RQ3
            host_i2c_data <= host_levels[0];
            host_i2c_clock <= host_levels[1]; // RQ4
            host_address_high <= (host_mode == comms_pin_mode_pkg::HOST_I2C) && address_level; // RQ5
            host_attention_n_oe <= reports_pending; // RQ15
        end
    end

    // Pins that only ever pull low hold a constant output level
    always_ff @(posedge clk or posedge rst_all)
    begin
        if (rst_all)
        begin
            host_serial_data_out <= 1'b0;
            host_attention_n_out <= 1'b0;
        end
        else
        begin
            host_serial_data_out <= 1'b0;
            host_attention_n_out <= 1'b0; // RQ15
        end
    end

    // ----------------------------------------------------------------
    // Slave SPI link domain
    // ----------------------------------------------------------------
    logic [7:0] link_shift;
    logic [2:0] link_count;
    logic [7:0] link_byte;
    logic link_toggle;

    // Shift MOSI in on the host clock; MISO echoes the previous byte.
    // Bit count is cleared by the select pin, so no link edge is needed
    // after the frame ends.
    always_ff @(posedge link_clk or posedge link_clear)
    begin
        if (link_clear)
        begin
            link_shift <= 8'h00;
            link_count <= 3'h0;
        end
        else
        begin
            link_shift <= {link_shift[6:0], host_address_pick_in}; // RQ5
            link_count <= link_count + 3'h1; // RQ3
        end
    end

    // Completed byte is held for eight link edges, long enough for the core
    always_ff @(posedge link_clk or posedge rst_all)
    begin
        if (rst_all)
        begin
            link_byte <= 8'h00;
            link_toggle <= 1'b0;
            link_miso <= 1'b0;
        end
        else
        begin
            link_miso <= link_byte[3'h7 - link_count]; // RQ2
            if (link_count == 3'h7 && !host_select_n_raw)
            begin
                link_byte <= {link_shift[6:0], host_address_pick_in};
                link_toggle <= ~link_toggle;
            end
        end
    end

    assign host_bus_select_strap_out = link_miso; // RQ2

    sync_two_flop #(.WIDTH(1)) toggle_sync (
        .clk(clk),
        .rst(rst_all),
        .async_in(link_toggle),
        .sync_out(toggle_seen)
    );

    // Toggle edge marks a new byte; the held byte is stable by then
    always_ff @(posedge clk or posedge rst_all)
    begin
        if (rst_all)
        begin
            toggle_prev <= 1'b0;
            host_byte_valid <= 1'b0;
            host_byte <= 8'h00;
        end
        else
        begin
            toggle_prev <= toggle_seen;
            host_byte_valid <= (toggle_seen != toggle_prev) && host_is_spi;
            if (toggle_seen != toggle_prev)
            begin
                host_byte <= link_byte;
            end
        end
    end

    // ----------------------------------------------------------------
    // Master communications port
    // ----------------------------------------------------------------
    comms_pin_mode_pkg::master_mode_type port_mode;
    assign port_mode = comms_pin_mode_pkg::master_mode_type'(master_mode);

    // One mode at a time; an illegal code releases every pin
    always_ff @(posedge clk or posedge rst_all)
    begin
        if (rst_all)
        begin
            master_port_out <= 4'h0;
            master_port_oe <= 4'h0;
        end
        else
        begin
            unique case (port_mode) // RQ6
                comms_pin_mode_pkg::MASTER_GPIO:
                begin
                    master_port_out <= parallel_out; // RQ7
                    master_port_oe <= `MASTER_OE_GPIO;
                end
                comms_pin_mode_pkg::MASTER_I2C:
                begin
                    // Open-drain data and clock, pin 2 input, pin 3 idle
                    master_port_out <= 4'h0; // RQ8
                    master_port_oe <= {2'b00, master_serial_clock_drive_low, master_serial_data_drive_low};
                end
                comms_pin_mode_pkg::MASTER_SPI:
                begin
                    master_port_out <= {master_target_select_n, 1'b0, master_shift_clock, master_data_out}; // RQ10
                    master_port_oe <= `MASTER_OE_SPI;
                end
                default:
                begin
                    master_port_out <= 4'h0;
                    master_port_oe <= 4'h0;
                end
            endcase
        end
    end

    // Data and clock levels read back in every mode; attention and MISO take idle values when not in their mode.
    // A shared attention line is only a level here: telling drivers apart
    // is left to I2C queries by the renderer.
    always_ff @(posedge clk or posedge rst_all)
    begin
        if (rst_all)
        begin
            master_serial_data <= 1'b1;
            master_serial_clock <= 1'b1;
            driver_attention_n <= 1'b1;
            master_data_in <= 1'b0;
        end
        else
        begin
            master_serial_data <= master_levels[0];
            master_serial_clock <= master_levels[1];
            driver_attention_n <= (port_mode == comms_pin_mode_pkg::MASTER_I2C) ? master_levels[2] : 1'b1; // RQ8 RQ9
            master_data_in <= (port_mode == comms_pin_mode_pkg::MASTER_SPI) && master_levels[2]; // RQ10
        end
    end

    // ----------------------------------------------------------------
    // General pins and press channels
    // ----------------------------------------------------------------
    logic [`GENERAL_PIN_COUNT-1:0] sync_claim;
    assign sync_claim = (`GENERAL_PIN_COUNT'(line_sync_enable) << `LINE_SYNC_PIN)
        | (`GENERAL_PIN_COUNT'(frame_sync_enable) << `FRAME_SYNC_PIN);

    // A pin claimed for sync is forced to input so it never fights the source
    genvar gi;
    generate
        for (gi = 0; gi < `GENERAL_PIN_COUNT; gi++)
        begin : general_lane
            always_ff @(posedge clk or posedge rst_all)
            begin
                if (rst_all)
                begin
                    general_io_oe[gi] <= 1'b0;
                    general_io_out[gi] <= 1'b0;
                    general_io_level[gi] <= 1'b1;
                end
                else
                begin
                    general_io_oe[gi] <= general_io_drive[gi] && !sync_claim[gi]; // RQ11 RQ12
                    general_io_out[gi] <= general_io_value[gi];
                    general_io_level[gi] <= general_levels[gi];
                end
            end
        end
    endgenerate

    // Sync levels pass only while enabled; press pattern follows config
    always_ff @(posedge clk or posedge rst_all)
    begin
        if (rst_all)
        begin
            line_sync_in <= 1'b0;
            frame_sync_in <= 1'b0;
            press_channels <= `PRESS_SINGLE_CHANNEL;
        end
        else
        begin
            line_sync_in <= line_sync_enable && general_levels[`LINE_SYNC_PIN]; // RQ12
            frame_sync_in <= frame_sync_enable && general_levels[`FRAME_SYNC_PIN];
            press_channels <= press_multi_channel ? `PRESS_ALL_CHANNELS : `PRESS_SINGLE_CHANNEL; // RQ14
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_mode_decided;
        host_mode == comms_pin_mode_pkg::HOST_PENDING ##1 host_mode != comms_pin_mode_pkg::HOST_PENDING;
    endsequence

    sequence s_byte_edge;
        toggle_seen != toggle_prev && host_is_spi;
    endsequence

    property p_mode_from_strap;
        @(posedge clk) disable iff (rst_all)
        s_mode_decided |-> (host_mode == comms_pin_mode_pkg::HOST_SPI) == $past(strap_level);
    endproperty
    a_mode_from_strap: assert property (p_mode_from_strap) else $error("mode differs from strap"); // RQ1

    property p_mode_held;
        @(posedge clk) disable iff (rst_all)
        host_mode != comms_pin_mode_pkg::HOST_PENDING |=> $stable(host_mode);
    endproperty
    a_mode_held: assert property (p_mode_held) else $error("host mode changed"); // RQ17

    property p_decide_time;
        @(posedge clk) disable iff (rst_all)
        $rose(host_mode_valid) |-> $past(host_mode_valid, 1) == 1'b0 ##0 settle_count == 2'h3;
    endproperty
    a_decide_time: assert property (p_decide_time) else $error("mode valid early"); // RQ1

    property p_miso_enable;
        @(posedge clk) disable iff (rst_all)
        s_mode_decided ##1 1'b1 |-> host_bus_select_strap_oe == (host_mode == comms_pin_mode_pkg::HOST_SPI);
    endproperty
    a_miso_enable: assert property (p_miso_enable) else $error("strap drive wrong"); // RQ2

    property p_gpio_outputs;
        @(posedge clk) disable iff (rst_all)
        port_mode == comms_pin_mode_pkg::MASTER_GPIO |=> master_port_oe == 4'hF && master_port_out == $past(parallel_out);
    endproperty
    a_gpio_outputs: assert property (p_gpio_outputs) else $error("gpio outputs wrong"); // RQ7

    property p_i2c_pins;
        @(posedge clk) disable iff (rst_all)
        port_mode == comms_pin_mode_pkg::MASTER_I2C |=> master_port_oe[3:2] == 2'b00 && master_port_out == 4'h0;
    endproperty
    a_i2c_pins: assert property (p_i2c_pins) else $error("master i2c pins wrong"); // RQ8

    property p_spi_pins;
        @(posedge clk) disable iff (rst_all)
        port_mode == comms_pin_mode_pkg::MASTER_SPI |=> master_port_oe == 4'hB
            && master_port_out[3] == $past(master_target_select_n) && master_port_out[0] == $past(master_data_out);
    endproperty
    a_spi_pins: assert property (p_spi_pins) else $error("master spi pins wrong"); // RQ10

    property p_attention;
        @(posedge clk) disable iff (rst_all)
        reports_pending [*2] |=> host_attention_n_oe && !host_attention_n_out;
    endproperty
    a_attention: assert property (p_attention) else $error("attention not driven"); // RQ15

    property p_sync_input;
        @(posedge clk) disable iff (rst_all)
        frame_sync_enable |=> !general_io_oe[`FRAME_SYNC_PIN];
    endproperty
    a_sync_input: assert property (p_sync_input) else $error("sync pin driven"); // RQ12

    property p_press;
        @(posedge clk) disable iff (rst_all)
        !press_multi_channel |=> press_channels == 4'h1;
    endproperty
    a_press: assert property (p_press) else $error("press pattern wrong"); // RQ14

    property p_byte_pulse;
        @(posedge clk) disable iff (rst_all)
        s_byte_edge |=> host_byte_valid ##1 !host_byte_valid;
    endproperty
    a_byte_pulse: assert property (p_byte_pulse) else $error("byte pulse wrong"); // RQ3

endmodule

// ---- hw/comms_pin_mode_pkg.sv ----
// Types shared by the communication pin multiplexer.
// Assumes nothing of its surroundings.
package comms_pin_mode_pkg;

    // Slave host interface picked by the strap
    typedef enum logic [1:0] {
        HOST_PENDING = 2'h0,
        HOST_I2C = 2'h1,
        HOST_SPI = 2'h2
    } host_mode_type;

    // Master port mode chosen by the renderer
    typedef enum logic [1:0] {
        MASTER_GPIO = 2'h0,
        MASTER_I2C = 2'h1,
        MASTER_SPI = 2'h2
    } master_mode_type;

endpackage

// ---- hw/sync_two_flop.sv ----
// Two flip-flop level synchroniser, one lane per bit.
// Assumes the inputs are asynchronous to clk and change slowly enough
// that each level is held for at least two clk edges.
`timescale 1ns/1ps
module sync_two_flop #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    // First stage is read by the second stage only
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stage_one <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end

endmodule

// ---- verif/host_spi_model.sv ----
// Host model: SPI frames on the link clock, attention sensed by level.
// Assumes the bench resolves shared pins from the mux enables.
`timescale 1ns/1ps
module host_spi_model (
    input wire logic attention_n,
    output logic link_clk = 1'b0,
    output logic select_n = 1'b1,
    output logic mosi = 1'b0,
    input wire logic miso,
    output logic [15:0] heard = 16'h0000,
    output logic pending_seen
);
    // Level, not edge: a missed edge would lose a report
    assign pending_seen = ~attention_n;
    // Two bytes back to back, MSB first; clock stands still outside frames
    task automatic send(input logic [15:0] data);
        select_n = 1'b0;
        #24;
        for (int i = 15; i >= 0; i--)
        begin
            mosi = data[i];
            #24 link_clk = 1'b1;
            #24 link_clk = 1'b0;
            // Reply bit is taken half a link period after it was launched
            heard = {heard[14:0], miso};
        end
        #24 select_n = 1'b1;
        mosi = ~mosi; // Released line shows no stale value
    endtask
endmodule

// ---- verif/tb.sv ----
// Bench for the pin multiplexer: mode rows, resets, host SPI link.
// Assumes the host model drives the link; pull-ups are resolved here.
`timescale 1ns/1ps
module tb;
    // ------------------------------------------------------------
    // Pins and pad resolution
    // ------------------------------------------------------------
    logic clk, rst, hard_reset_n, strap, sclk_lvl, addr, i2c_low, pending, line_en, frame_en, multi;
    logic s_out, s_oe, d_out, d_oe, a_out, a_oe, is_spi, mode_ok, i2c_d, i2c_c, addr_hi, bvalid;
    logic m_sda, m_scl, m_att_n, m_miso, line_in, frame_in, lclk, sel_n, mosi, seen;
    logic [1:0] mode;
    logic [3:0] pout, mp_ext, mp_out, mp_oe, press;
    logic [4:0] ctl, gdrive, gval, gext, g_out, g_oe, glevel;
    logic [7:0] hbyte;
    logic [15:0] heard;
    logic [7:0] got[$];
    logic [18:0] rows[7];
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    wire strap_pin = s_oe ? s_out : strap;
    wire hsd = is_spi ? lclk : ~d_oe;
    wire hsc = is_spi ? sel_n : sclk_lvl;
    wire hap = is_spi ? mosi : addr;
    wire att = a_oe ? a_out : 1'b1;
    wire [3:0] mp_in = (mp_oe & mp_out) | (~mp_oe & mp_ext);
    wire [4:0] g_in = (g_oe & g_out) | (~g_oe & gext);
    // Core clock, 20 ns
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    comms_pin_mode_mux i_dut (.clk(clk), .rst(rst), .hard_reset_n(hard_reset_n), .link_clk(lclk),
        .host_bus_select_strap_in(strap_pin), .host_bus_select_strap_out(s_out),
        .host_bus_select_strap_oe(s_oe), .host_serial_data_in(hsd), .host_serial_data_out(d_out),
        .host_serial_data_oe(d_oe), .host_serial_clock_in(hsc), .host_address_pick_in(hap),
        .host_attention_n_out(a_out), .host_attention_n_oe(a_oe), .host_i2c_data_drive_low(i2c_low),
        .reports_pending(pending), .host_is_spi(is_spi), .host_mode_valid(mode_ok), .host_i2c_data(i2c_d),
        .host_i2c_clock(i2c_c), .host_address_high(addr_hi), .host_byte_valid(bvalid), .host_byte(hbyte),
        .master_port_in(mp_in), .master_port_out(mp_out), .master_port_oe(mp_oe), .master_mode(mode),
        .parallel_out(pout), .master_serial_data_drive_low(ctl[4]), .master_serial_clock_drive_low(ctl[3]),
        .master_data_out(ctl[2]), .master_shift_clock(ctl[1]), .master_target_select_n(ctl[0]),
        .master_serial_data(m_sda), .master_serial_clock(m_scl), .driver_attention_n(m_att_n),
        .master_data_in(m_miso), .general_io_in(g_in), .general_io_out(g_out), .general_io_oe(g_oe),
        .general_io_drive(gdrive), .general_io_value(gval), .line_sync_enable(line_en),
        .frame_sync_enable(frame_en), .general_io_level(glevel), .line_sync_in(line_in),
        .frame_sync_in(frame_in), .press_multi_channel(multi), .press_channels(press));
    host_spi_model i_host (.attention_n(att), .link_clk(lclk), .select_n(sel_n), .mosi(mosi),
        .miso(strap_pin), .heard(heard), .pending_seen(seen));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic results();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Hang guard, well beyond the roughly 120 cycles of the run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            results();
        end
    end
    // Collect every byte the link hands over
    always @(posedge clk)
        if (bvalid === 1'b1)
            got.push_back(hbyte);
    // Rows: mode, parallel out, serial drives, expected enables, expected driven levels
    initial
    begin
        {rst, hard_reset_n, strap, sclk_lvl, addr, i2c_low, pending, line_en, frame_en, multi} = 10'h3C0;
        {mode, pout, ctl, mp_ext, gdrive, gval, gext} = '0;
        rows = '{{2'h0, 4'h5, 5'h00, 4'hF, 4'h5}, {2'h0, 4'hA, 5'h00, 4'hF, 4'hA},
                 {2'h1, 4'h0, 5'h10, 4'h1, 4'h0}, {2'h1, 4'hF, 5'h08, 4'h2, 4'h0},
                 {2'h2, 4'h0, 5'h05, 4'hB, 4'h9}, {2'h2, 4'hF, 5'h02, 4'hB, 4'h2},
                 {2'h3, 4'hF, 5'h1F, 4'h0, 4'h0}};
        tick(10);
        rst = 1'b0;
        tick(7);
        chk(8'({mode_ok, is_spi, s_oe}), 8'h7);
        i_host.send(16'hA53C);
        tick(8);
        chk(8'(got.size()), 8'h2);
        chk(got[0], 8'hA5);
        chk(got[1], 8'h3C);
        chk(heard[15:8], 8'h00);
        chk(heard[7:0], 8'hA5);
        pending = 1'b1;
        tick(2);
        chk(8'({a_oe, a_out, seen}), 8'h5);
        pending = 1'b0;
        tick(2);
        chk(8'({a_oe, seen}), 8'h0);
        foreach (rows[i])
        begin
            {mode, pout, ctl} = rows[i][18:8];
            tick(2);
            chk(8'(mp_oe), 8'(rows[i][7:4]));
            chk(8'(mp_out & mp_oe), 8'(rows[i][3:0]));
        end
        // Shared attention line held low by a driver, data line left high
        {mode, ctl, mp_ext} = {2'h1, 5'h00, 4'h1};
        tick(4);
        chk(8'({m_scl, m_sda, m_att_n, m_miso}), 8'h4);
        {mode, mp_ext} = {2'h2, 4'h4};
        tick(4);
        chk(8'({m_scl, m_sda, m_att_n, m_miso}), 8'h3);
        {gdrive, gval, gext, line_en, frame_en} = {5'h1F, 5'h0A, 5'h06, 2'h3};
        tick(4);
        chk(8'(g_oe), 8'h19);
        chk(8'({line_in, frame_in, glevel}), 8'h6E);
        chk(8'(press), 8'h1);
        multi = 1'b1;
        tick(2);
        chk(8'(press), 8'hF);
        // Hard reset mid-run, strap now low: host side comes back as I2C
        strap = 1'b0;
        hard_reset_n = 1'b0;
        tick(3);
        chk(8'({mode_ok, s_oe, press}), 8'h01);
        chk(8'(mp_oe), 8'h0);
        hard_reset_n = 1'b1;
        tick(7);
        {addr, i2c_low, sclk_lvl} = 3'h6;
        tick(4);
        chk(8'({d_out, mode_ok, is_spi, s_oe, d_oe, addr_hi, i2c_c, i2c_d}), 8'h4C);
        strap = 1'b1;
        tick(6);
        chk(8'({mode_ok, is_spi, s_oe}), 8'h4);
        results();
    end
endmodule
